// ===== pkg/ldsr_defines.svh
`ifndef LDSR_DEFINES_SVH
`define LDSR_DEFINES_SVH

// Shift register lengths for the two loading modes.
`define LDSR_GS_BITS 192
`define LDSR_DC_BITS 96
`define LDSR_CHANNELS 16
`define LDSR_GS_W 12
`define LDSR_CNT_RST 12'h000

// Status field positions, as bit indices from bit 0, at the top of the active length.
`define LDSR_LOD_GS_LSB 176
`define LDSR_TEF_GS_POS 175
`define LDSR_LOD_DC_LSB 80
`define LDSR_TEF_DC_POS 79

// Timing, as printed and as cycles of the 100 MHz system clock.
`define LDSR_CLK_NS 10
`define LDSR_STAGGER_NS 20
`define LDSR_STAGGER_CYC (`LDSR_STAGGER_NS / `LDSR_CLK_NS)
`define LDSR_LOD_DLY_NS 1000
`define LDSR_LOD_DLY_CYC \
  ((`LDSR_LOD_DLY_NS + `LDSR_CLK_NS - 1) / `LDSR_CLK_NS)
`define LDSR_LOD_CNT_W 7

// Input FIFO shape.
`define LDSR_FIFO_W 1
`define LDSR_FIFO_D 8

`endif

// ===== pkg/ldsr_pkg.sv
`default_nettype none
`include "ldsr_defines.svh"

package ldsr_pkg;

  // Loading mode chosen by the mode select input.
  typedef enum logic [0:0] {
    LDSR_MODE_GS = 1'b0,
    LDSR_MODE_DC = 1'b1
  } ldsr_mode_t;

  // Phase of the latch strobe as seen by the core.
  typedef enum logic [1:0] {
    LDSR_LAT_IDLE = 2'b00,
    LDSR_LAT_WAIT = 2'b01,
    LDSR_LAT_OPEN = 2'b10
  } ldsr_lat_t;

  // Whole state of the top module.
  typedef struct packed {
    logic                        sclk_q1;
    logic                        sclk_q2;
    logic                        sclk_d;
    logic                        sin_q1;
    logic                        sin_q2;
    logic                        lat_q1;
    logic                        lat_q2;
    logic                        mode_q1;
    logic                        mode_q2;
    logic                        blank_q1;
    logic                        blank_q2;
    logic                        temp_q1;
    logic                        temp_q2;
    logic                        gsclk_q1;
    logic                        gsclk_q2;
    logic                        gsclk_d;
    logic [`LDSR_CHANNELS-1:0]   lowv_q1;
    logic [`LDSR_CHANNELS-1:0]   lowv_q2;
    logic [`LDSR_GS_BITS-1:0]    sr;
    logic [`LDSR_GS_BITS-1:0]    gs;
    logic [`LDSR_DC_BITS-1:0]    dc;
    ldsr_lat_t                   lat;
    ldsr_mode_t                  mode;
    logic [`LDSR_GS_W-1:0]       cnt;
    logic [`LDSR_CHANNELS-1:0]   req;
    logic                        thermal_flag;
    logic                        err_n;
    logic                        err_oe_n;
    logic                        serial_data_output;
    logic                        ready;
  } ldsr_top_st_t;

endpackage

`default_nettype wire

// ===== src/ldsr_fifo.sv
`timescale 1ns/10ps
`default_nettype none

// Small synchronous FIFO with valid and ready on both sides.
module ldsr_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_rstn,
  input  wire logic [WIDTH-1:0] i_in_data,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  output logic [WIDTH-1:0]      o_out_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } ldsr_fifo_st_t;

  ldsr_fifo_st_t s;
  ldsr_fifo_st_t next_s;
  logic          push;
  logic          pop;

  // Flags come straight from the count, so full and empty are exact.
  assign o_in_ready  = (s.cnt != (AW+1)'(DEPTH));
  assign o_out_valid = (s.cnt != '0);
  assign o_out_data  = s.mem[s.rp];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  // Pointers wrap at the depth, which need not be a power of two.
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wp] = i_in_data;
      next_s.wp = (s.wp == AW'(DEPTH - 1)) ? '0 : s.wp + 1'b1;
    end
    if (pop) begin
      next_s.rp = (s.rp == AW'(DEPTH - 1)) ? '0 : s.rp + 1'b1;
    end
    next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // State register.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule

`default_nettype wire

// ===== src/ldsr_chan.sv
`timescale 1ns/10ps
`default_nettype none

`include "ldsr_defines.svh"

// One output channel: staggered switching and open LED detection.
module ldsr_chan #(
  parameter int IDX = 0
) (
  input  wire logic i_clk,
  input  wire logic i_rstn,
  input  wire logic i_req,
  input  wire logic i_low_v,
  output logic      o_on,
  output logic      o_open
);

  localparam int TAP = IDX * `LDSR_STAGGER_CYC;
  localparam int TI  = (TAP == 0) ? 0 : TAP - 1;
  localparam int LW  = TI + 1;

  typedef struct packed {
    logic [LW-1:0]                line;
    logic                         on;
    logic [`LDSR_LOD_CNT_W-1:0]   cnt;
    logic                         open;
  } ldsr_chan_st_t;

  ldsr_chan_st_t s;
  ldsr_chan_st_t next_s;
  logic          dly;

  assign o_on   = s.on;
  assign o_open = s.open;

  // A delay line gives each channel its own offset on both edges, which
  // spreads the inrush current of a common switching event.
  always_comb begin
    next_s = s;
    // The cast drops the oldest sample, which has left the line.
    next_s.line = LW'({s.line, i_req});
    dly = (TAP == 0) ? i_req : s.line[TI];
    next_s.on = dly; // RL18
    // The settle timer restarts at every turn-on and saturates.
    if (!s.on) begin
      next_s.cnt = '0;
    end else if (s.cnt != `LDSR_LOD_CNT_W'(`LDSR_LOD_DLY_CYC)) begin
      next_s.cnt = s.cnt + 1'b1;
    end
    next_s.open = s.on & i_low_v &
      (s.cnt == `LDSR_LOD_CNT_W'(`LDSR_LOD_DLY_CYC)); // RL14
  end

  // State register.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule

`default_nettype wire

// ===== src/ldsr_top.sv
`timescale 1ns/10ps
`default_nettype none

`include "ldsr_defines.svh"

// Overview of operation
// RL1: Sample serial data on each shift clock rise.
// RL2: Data registers transparent while latch high, hold after.
// RL3: Host sends most significant bit first.
// RL4: Shift length 96 for correction, 192 grayscale.
// RL5: Shifting during a PWM cycle leaves outputs alone.
// RL6: Host should latch grayscale at cycle end.
// RL7: Latched grayscale takes effect at once.
// RL8: Serial output taken from shift register end.
// RL9: Serial output also carries status back.
// RL10: Error pin low on thermal or open LED.
// RL11: Blanking removes open LED from error pin.
// RL12: Thermal flag follows the temperature monitor.
// RL13: Thermal flag appears in serial status.
// RL14: Open flag needs on, settle delay, low voltage.
// RL15: One open LED status bit per channel.
// RL16: Open flags captured on latch falling edge.
// RL17: Host pulses latch then shifts status out.
// RL18: Each channel switches 20 ns after previous.
// RL19: Mode select high gives 96-bit correction mode.
// RL20: Host holds shift clock and data during latch.
// RL21: Blanking disables outputs, resets grayscale counter.
module ldsr_top (
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RSTN,
  input  wire logic        I_SERIAL_CLK,
  input  wire logic        I_SERIAL_DATA_INPUT,
  input  wire logic        I_LATCH_STROBE,
  input  wire logic        I_MODE_SELECT_PROGRAM,
  input  wire logic        I_BLANK,
  input  wire logic        I_GS_CLK,
  input  wire logic        I_TEMP_OVER,
  input  wire logic [15:0] I_CH_LOW_V,
  output logic             O_SERIAL_DATA_OUTPUT,
  output logic             O_ERROR_OUTPUT_N,
  output logic             O_ERROR_OUTPUT_N_OE_N,
  output logic             O_INPUT_READY,
  output logic [15:0]      O_CHANNEL_SINK_OUTPUT,
  output logic [15:0]      O_OPEN_LED_FLAG,
  output logic             O_THERMAL_FLAG,
  output logic [191:0]     O_GS_DATA,
  output logic [95:0]      O_DC_DATA
);

  ldsr_pkg::ldsr_top_st_t    s;
  ldsr_pkg::ldsr_top_st_t    next_s;
  logic                      fifo_bit;
  logic                      fifo_valid;
  logic                      fifo_ready;
  logic                      pop_ready;
  logic                      sclk_rise;
  logic                      gsclk_rise;
  logic [`LDSR_CHANNELS-1:0] ch_on;
  logic [`LDSR_CHANNELS-1:0] ch_open;

  // Places the open flags and the thermal flag at the top of the
  // active shift length, so they leave the serial output first.
  function automatic logic [`LDSR_GS_BITS-1:0] place_status(
    input logic [`LDSR_GS_BITS-1:0]  sr,
    input ldsr_pkg::ldsr_mode_t      mode,
    input logic [`LDSR_CHANNELS-1:0] open_led_flag,
    input logic                      thermal_flag
  );
    logic [`LDSR_GS_BITS-1:0] r;
    r = sr;
    if (mode == ldsr_pkg::LDSR_MODE_DC) begin
      r[`LDSR_LOD_DC_LSB +: `LDSR_CHANNELS] = open_led_flag; // RL15
      r[`LDSR_TEF_DC_POS] = thermal_flag; // RL13
    end else begin
      r[`LDSR_LOD_GS_LSB +: `LDSR_CHANNELS] = open_led_flag; // RL15
      r[`LDSR_TEF_GS_POS] = thermal_flag; // RL13
    end
    return r;
  endfunction

  // Picks the last bit of the shift register for the active length.
  function automatic logic chain_end(
    input logic [`LDSR_GS_BITS-1:0] sr,
    input ldsr_pkg::ldsr_mode_t     mode
  );
    if (mode == ldsr_pkg::LDSR_MODE_DC) begin
      return sr[`LDSR_DC_BITS-1];
    end else begin
      return sr[`LDSR_GS_BITS-1];
    end
  endfunction

  // Edges are found on the second synchroniser stage only.
  assign sclk_rise  = s.sclk_q2 & ~s.sclk_d;
  assign gsclk_rise = s.gsclk_q2 & ~s.gsclk_d;

  // The capture cycle stalls the drain, since both it and a pop would
  // write the shift register in the same cycle.
  assign pop_ready = ~((s.lat == ldsr_pkg::LDSR_LAT_OPEN) & ~s.lat_q2);

  // Sampled serial bits queue here; the drain is one bit a cycle, far
  // faster than the shift clock, so the queue only fills under stalls.
  ldsr_fifo #(
    .WIDTH (`LDSR_FIFO_W),
    .DEPTH (`LDSR_FIFO_D)
  ) u_fifo (
    .i_clk       (I_CLK_SYS),
    .i_rstn      (I_RSTN),
    .i_in_data   (s.sin_q2),
    .i_in_valid  (sclk_rise),
    .o_in_ready  (fifo_ready),
    .o_out_data  (fifo_bit),
    .o_out_valid (fifo_valid),
    .i_out_ready (pop_ready)
  );

  // Channel drivers, each with its own stagger offset.
  for (genvar ch = 0; ch < `LDSR_CHANNELS; ch++) begin : g_ch
    ldsr_chan #(
      .IDX (ch)
    ) u_chan (
      .i_clk   (I_CLK_SYS),
      .i_rstn  (I_RSTN),
      .i_req   (s.req[ch]),
      .i_low_v (s.lowv_q2[ch]),
      .o_on    (ch_on[ch]),
      .o_open  (ch_open[ch])
    );
  end

  // All pins pass two flip-flops before any logic looks at them.
  always_comb begin
    next_s = s;
    next_s.sclk_q1  = I_SERIAL_CLK;
    next_s.sclk_q2  = s.sclk_q1;
    next_s.sclk_d   = s.sclk_q2;
    next_s.sin_q1   = I_SERIAL_DATA_INPUT;
    next_s.sin_q2   = s.sin_q1;
    next_s.lat_q1   = I_LATCH_STROBE;
    next_s.lat_q2   = s.lat_q1;
    next_s.mode_q1  = I_MODE_SELECT_PROGRAM;
    next_s.mode_q2  = s.mode_q1;
    next_s.blank_q1 = I_BLANK;
    next_s.blank_q2 = s.blank_q1;
    next_s.temp_q1  = I_TEMP_OVER;
    next_s.temp_q2  = s.temp_q1;
    next_s.gsclk_q1 = I_GS_CLK;
    next_s.gsclk_q2 = s.gsclk_q1;
    next_s.gsclk_d  = s.gsclk_q2;
    next_s.lowv_q1  = I_CH_LOW_V;
    next_s.lowv_q2  = s.lowv_q1;

    // The mode select pin sets the active shift length.
    next_s.mode = s.mode_q2 ? ldsr_pkg::LDSR_MODE_DC
                            : ldsr_pkg::LDSR_MODE_GS; // RL19 RL4

    // Each queued bit enters at the bottom, so the first bit sent ends
    // up at the top of the highest field.
    if (fifo_valid && pop_ready) begin
      next_s.sr = {s.sr[`LDSR_GS_BITS-2:0], fifo_bit}; // RL1 RL3
    end

    // Latch phases. A rise waits until queued bits have drained so the
    // registers never see a half-shifted word.
    case (s.lat)
      ldsr_pkg::LDSR_LAT_IDLE: begin
        if (s.lat_q2) begin
          next_s.lat = ldsr_pkg::LDSR_LAT_WAIT;
        end
      end
      ldsr_pkg::LDSR_LAT_WAIT: begin
        if (!fifo_valid) begin
          next_s.lat = ldsr_pkg::LDSR_LAT_OPEN;
        end
      end
      ldsr_pkg::LDSR_LAT_OPEN: begin
        if (!s.lat_q2) begin
          next_s.lat = ldsr_pkg::LDSR_LAT_IDLE;
          next_s.sr = place_status(s.sr, s.mode, ch_open,
                                   s.thermal_flag); // RL16 RL9
        end
      end
      default: begin
        next_s.lat = ldsr_pkg::LDSR_LAT_IDLE;
      end
    endcase

    // Transparent while open: the registers follow the shift register
    // and keep the last value once the strobe drops. Grayscale takes
    // effect at once, even in the middle of a PWM cycle.
    if (s.lat == ldsr_pkg::LDSR_LAT_OPEN && s.lat_q2) begin // RL2
      if (s.mode == ldsr_pkg::LDSR_MODE_DC) begin
        next_s.dc = s.sr[`LDSR_DC_BITS-1:0];
      end else begin
        next_s.gs = s.sr; // RL7
      end
    end

    // Grayscale counter, held at zero while blanked.
    if (s.blank_q2) begin
      next_s.cnt = `LDSR_CNT_RST; // RL21
    end else if (gsclk_rise) begin
      next_s.cnt = s.cnt + 1'b1;
    end

    // Channel requests read only the latched grayscale values, never
    // the shift register, so shifting does not disturb the outputs.
    for (int ch = 0; ch < `LDSR_CHANNELS; ch++) begin
      next_s.req[ch] = ~s.blank_q2 &
        (s.cnt < s.gs[ch*`LDSR_GS_W +: `LDSR_GS_W]); // RL5 RL21
    end

    // Thermal flag mirrors the monitor in both directions.
    next_s.thermal_flag = s.temp_q2; // RL12

    // Open-drain error pin: enable low pulls it to ground.
    next_s.err_oe_n = ~(s.thermal_flag |
      ((|ch_open) & ~s.blank_q2)); // RL10 RL11
    next_s.err_n = next_s.err_oe_n;

    // Chain output follows the end of the active length.
    next_s.serial_data_output = chain_end(s.sr, s.mode); // RL8

    // Registered view of whether the queue can take another bit.
    next_s.ready = fifo_ready;
  end

  // State register; the error pin starts released.
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      s <= '0;
      s.err_n <= 1'b1;
      s.err_oe_n <= 1'b1;
      s.ready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs come from the state register or the channel flip-flops.
  assign O_SERIAL_DATA_OUTPUT  = s.serial_data_output;
  assign O_ERROR_OUTPUT_N      = s.err_n;
  assign O_ERROR_OUTPUT_N_OE_N = s.err_oe_n;
  assign O_INPUT_READY         = s.ready;
  assign O_CHANNEL_SINK_OUTPUT = ch_on;
  assign O_OPEN_LED_FLAG       = ch_open;
  assign O_THERMAL_FLAG        = s.thermal_flag;
  assign O_GS_DATA             = s.gs;
  assign O_DC_DATA             = s.dc;

endmodule

`default_nettype wire

// ===== src/ldsr_chan_fix_note_unused.sv
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ===== tb/ldsr_top_properties.sv
`timescale 1ns/10ps
`default_nettype none

// Pin level checks; windows of five, six or eight cycles cover the synchronisers.
module ldsr_top_properties (
  input wire logic         I_CLK_SYS,
  input wire logic         I_RSTN,
  input wire logic         I_SERIAL_CLK,
  input wire logic         I_LATCH_STROBE,
  input wire logic         I_MODE_SELECT_PROGRAM,
  input wire logic         I_BLANK,
  input wire logic         I_TEMP_OVER,
  input wire logic [15:0]  I_CH_LOW_V,
  input wire logic         O_SERIAL_DATA_OUTPUT,
  input wire logic         O_ERROR_OUTPUT_N_OE_N,
  input wire logic [15:0]  O_CHANNEL_SINK_OUTPUT,
  input wire logic [15:0]  O_OPEN_LED_FLAG,
  input wire logic         O_THERMAL_FLAG,
  input wire logic [191:0] O_GS_DATA
);
  // One clock domain, so clock and reset are given once.
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RSTN);

  // Error pin and thermal flag against their causes.
  property p_therm_on;
    I_TEMP_OVER [*6] |-> O_THERMAL_FLAG && !O_ERROR_OUTPUT_N_OE_N;
  endproperty
  a_therm_on: assert property (p_therm_on) else $error("hot, no flag");
  property p_therm_off;
    !I_TEMP_OVER [*6] |-> !O_THERMAL_FLAG;
  endproperty
  a_therm_off: assert property (p_therm_off) else $error("flag stuck");
  property p_mask;
    (!I_TEMP_OVER && I_BLANK) [*8] |-> O_ERROR_OUTPUT_N_OE_N;
  endproperty
  a_mask: assert property (p_mask) else $error("open not masked");
  property p_open_err;
    (|O_OPEN_LED_FLAG && !I_BLANK) [*5] |-> !O_ERROR_OUTPUT_N_OE_N;
  endproperty
  a_open_err: assert property (p_open_err)
    else $error("open not shown");
  property p_quiet;
    (!I_TEMP_OVER && I_CH_LOW_V == 16'h0000) [*8] |-> O_ERROR_OUTPUT_N_OE_N;
  endproperty
  a_quiet: assert property (p_quiet) else $error("pin not released");

  // Channel 0 output, grayscale register and serial output at rest.
  property p_blank_off;
    I_BLANK [*8] |-> !O_CHANNEL_SINK_OUTPUT[0];
  endproperty
  a_blank_off: assert property (p_blank_off)
    else $error("blank ignored");
  property p_hold;
    !I_LATCH_STROBE [*8] |-> $stable(O_GS_DATA);
  endproperty
  a_hold: assert property (p_hold) else $error("data moved");
  // A mode change moves the chain end, so the mode must be still too.
  property p_serial_data_output_still;
    (!I_SERIAL_CLK && !I_LATCH_STROBE && $stable(I_MODE_SELECT_PROGRAM))
      [*8] |-> $stable(O_SERIAL_DATA_OUTPUT);
  endproperty
  a_serial_data_output_still: assert property (p_serial_data_output_still)
    else $error("serial_data_output moved");

  c_tef: cover property (O_THERMAL_FLAG);
  c_open: cover property (|O_OPEN_LED_FLAG);
  c_latch: cover property ($fell(I_LATCH_STROBE));
endmodule

bind ldsr_top ldsr_top_properties u_props (
  .I_CLK_SYS             (I_CLK_SYS),
  .I_RSTN                (I_RSTN),
  .I_SERIAL_CLK          (I_SERIAL_CLK),
  .I_LATCH_STROBE        (I_LATCH_STROBE),
  .I_MODE_SELECT_PROGRAM (I_MODE_SELECT_PROGRAM),
  .I_BLANK               (I_BLANK),
  .I_TEMP_OVER           (I_TEMP_OVER),
  .I_CH_LOW_V            (I_CH_LOW_V),
  .O_SERIAL_DATA_OUTPUT  (O_SERIAL_DATA_OUTPUT),
  .O_ERROR_OUTPUT_N_OE_N (O_ERROR_OUTPUT_N_OE_N),
  .O_CHANNEL_SINK_OUTPUT (O_CHANNEL_SINK_OUTPUT),
  .O_OPEN_LED_FLAG       (O_OPEN_LED_FLAG),
  .O_THERMAL_FLAG        (O_THERMAL_FLAG),
  .O_GS_DATA             (O_GS_DATA)
);

`default_nettype wire

// ===== tb/ldsr_host_model.sv
`timescale 1ns/10ps
`default_nettype none

// Host controller: shifts frames at 80 ns per bit and reads back status.
module ldsr_host_model (
  input  wire logic i_clk,
  input  wire logic i_serial_data_output,
  output logic      o_sclk,
  output logic      o_sdata,
  output logic      o_latch,
  output logic      o_rx_bit,
  output logic      o_rx_valid
);
  // The shift clock stands low outside frames.
  initial begin
    o_sclk = 1'b0;
    o_sdata = 1'b0;
    o_latch = 1'b0;
    o_rx_bit = 1'b0;
    o_rx_valid = 1'b0;
  end

  // Data is set 40 ns before the rise and held 40 ns after it.
  task automatic shift(input logic [191:0] d, input int n, input logic rx);
    for (int i = n - 1; i >= 0; i--) begin
      o_sdata <= d[i];
      repeat (4) @(posedge i_clk);
      o_sclk <= 1'b1;
      o_rx_bit <= i_serial_data_output;
      o_rx_valid <= rx;
      @(posedge i_clk);
      o_rx_valid <= 1'b0;
      repeat (3) @(posedge i_clk);
      o_sclk <= 1'b0;
    end
    repeat (4) @(posedge i_clk);
    o_sdata <= ~o_sdata; // Released line does not keep the last bit.
  endtask

  // Serial lines stay frozen while the strobe is high.
  task automatic latch_pulse();
    o_latch <= 1'b1;
    repeat (10) @(posedge i_clk);
    o_latch <= 1'b0;
    repeat (12) @(posedge i_clk);
  endtask
endmodule

`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb;
  logic          I_CLK_SYS, I_RSTN, I_MODE_SELECT_PROGRAM, I_BLANK;
  logic          I_GS_CLK, I_TEMP_OVER, I_SERIAL_CLK, I_SERIAL_DATA_INPUT;
  logic          I_LATCH_STROBE, serial_data_output, oe_n, ready, thermal_flag, rx_bit, rx_valid;
  logic          err_n;
  logic [15:0]   I_CH_LOW_V, ch, open, lowv;
  logic [191:0]  gs, d1, d2;
  logic [95:0]   dc;
  logic          exp_q[$];
  int            num_errors, compares, seed;
  int            fell[16];

  ldsr_top u_dut (
    .I_CLK_SYS(I_CLK_SYS), .I_RSTN(I_RSTN), .I_SERIAL_CLK(I_SERIAL_CLK),
    .I_SERIAL_DATA_INPUT(I_SERIAL_DATA_INPUT),
    .I_LATCH_STROBE(I_LATCH_STROBE),
    .I_MODE_SELECT_PROGRAM(I_MODE_SELECT_PROGRAM), .I_BLANK(I_BLANK),
    .I_GS_CLK(I_GS_CLK), .I_TEMP_OVER(I_TEMP_OVER), .I_CH_LOW_V(I_CH_LOW_V),
    .O_SERIAL_DATA_OUTPUT(serial_data_output), .O_ERROR_OUTPUT_N(err_n),
    .O_ERROR_OUTPUT_N_OE_N(oe_n), .O_INPUT_READY(ready),
    .O_CHANNEL_SINK_OUTPUT(ch), .O_OPEN_LED_FLAG(open),
    .O_THERMAL_FLAG(thermal_flag), .O_GS_DATA(gs), .O_DC_DATA(dc));

  ldsr_host_model u_host (
    .i_clk(I_CLK_SYS), .i_serial_data_output(serial_data_output), .o_sclk(I_SERIAL_CLK),
    .o_sdata(I_SERIAL_DATA_INPUT), .o_latch(I_LATCH_STROBE),
    .o_rx_bit(rx_bit), .o_rx_valid(rx_valid));

  initial begin
    I_CLK_SYS = 1'b0;
    forever #5 I_CLK_SYS = ~I_CLK_SYS;
  end

  task automatic chk(input string s, input logic [191:0] e, logic [191:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic note(input logic [191:0] v);
    for (int i = 191; i >= 0; i--) exp_q.push_back(v[i]);
  endtask

  task automatic rnd(output logic [191:0] v);
    for (int k = 0; k < 6; k++) v[32*k +: 32] = $urandom();
  endtask

  task automatic finish_test();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Each bit read back by the host is matched with the oldest note.
  always @(posedge I_CLK_SYS) begin
    if (rx_valid === 1'b1 && exp_q.size() > 0)
      chk("serial out", 192'(exp_q.pop_front()), 192'(rx_bit));
  end

  // A run is about 5900 cycles; a normal run ends well before this limit.
  initial begin
    repeat (40000) @(posedge I_CLK_SYS);
    num_errors++;
    $display("watchdog expired");
    finish_test();
  end

  // Main sequence; the grayscale clock stays still, so no cycle is cut.
  initial begin
    {I_RSTN, I_MODE_SELECT_PROGRAM, I_BLANK, I_TEMP_OVER} = 4'h0;
    I_GS_CLK = 1'b0;
    I_CH_LOW_V = 16'h0000;
    fell = '{default: 0};
    seed = $urandom(28);
    repeat (12) @(posedge I_CLK_SYS);
    I_RSTN <= 1'b1;
    repeat (4) @(negedge I_CLK_SYS);
    chk("error enable", 192'h1, 192'(oe_n));
    chk("error pin", 192'h1, 192'(err_n));
    chk("input ready", 192'h1, 192'(ready));
    $display("test reset done");
    rnd(d1);
    for (int c = 0; c < 16; c++) d1[12*c] = 1'b1;
    note(192'h0);
    @(posedge I_CLK_SYS);
    u_host.shift(d1, 192, 1'b1);
    @(negedge I_CLK_SYS);
    chk("gs before latch", 192'h0, gs);
    @(posedge I_CLK_SYS);
    u_host.latch_pulse();
    @(negedge I_CLK_SYS);
    chk("gs latched", d1, gs);
    $display("test grayscale done");
    lowv = 16'($urandom()) | 16'h8001;
    @(posedge I_CLK_SYS);
    I_CH_LOW_V <= lowv;
    repeat (150) @(negedge I_CLK_SYS);
    chk("open flags", 192'(lowv), 192'(open));
    chk("error enable", 192'h0, 192'(oe_n));
    @(posedge I_CLK_SYS);
    I_BLANK <= 1'b1;
    for (int t = 1; t < 60; t++) begin
      @(negedge I_CLK_SYS);
      for (int c = 0; c < 16; c++) begin
        if (ch[c] !== 1'b1 && fell[c] == 0) fell[c] = t;
      end
    end
    for (int c = 0; c < 16; c++) begin
      chk("stagger", 192'(fell[0] + 2 * c), 192'(fell[c]));
    end
    chk("blanked", 192'h0, 192'(ch));
    chk("error enable", 192'h1, 192'(oe_n));
    @(posedge I_CLK_SYS);
    I_BLANK <= 1'b0;
    I_TEMP_OVER <= 1'b1;
    repeat (150) @(negedge I_CLK_SYS);
    chk("thermal", 192'h1, 192'(thermal_flag));
    chk("error enable", 192'h0, 192'(oe_n));
    chk("error pin", 192'h0, 192'(err_n));
    $display("test error flags done");
    note({17'h0, d1[174:0]});
    @(posedge I_CLK_SYS);
    u_host.shift(d1, 192, 1'b1);
    @(posedge I_CLK_SYS);
    u_host.latch_pulse();
    rnd(d2);
    note({lowv, 1'b1, d1[174:0]});
    @(posedge I_CLK_SYS);
    u_host.shift(d2, 192, 1'b1);
    @(negedge I_CLK_SYS);
    chk("gs kept", d1, gs);
    @(posedge I_CLK_SYS);
    I_TEMP_OVER <= 1'b0;
    repeat (10) @(negedge I_CLK_SYS);
    chk("thermal", 192'h0, 192'(thermal_flag));
    $display("test status done");
    @(posedge I_CLK_SYS);
    I_MODE_SELECT_PROGRAM <= 1'b1;
    repeat (8) @(posedge I_CLK_SYS);
    u_host.shift({96'h0, d2[191:96]}, 96, 1'b0);
    @(posedge I_CLK_SYS);
    u_host.latch_pulse();
    @(negedge I_CLK_SYS);
    chk("dc latched", 192'(d2[191:96]), 192'(dc));
    chk("gs kept", d1, gs);
    chk("notes left", 192'h0, 192'(exp_q.size()));
    $display("test dot correction done");
    finish_test();
  end
endmodule

`default_nettype wire
